// ### boie_pkg.sv
// Constants and types for the bit-oriented instruction execute block.
// Assumes a 14-bit instruction word and an 8-bit file register data path.
package boie_pkg;
	localparam int INSTR_W = 14;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;
	localparam int BIT_W = 3;
	localparam int ADDR_LSB = 0;
	localparam int BIT_LSB = 7;
	localparam int DEST_POS = 7;
	localparam int OP4_LSB = 10;
	localparam int OP6_LSB = 8;
	localparam logic [3:0] OP_BIT_CLEAR = 4'h4;
	localparam logic [3:0] OP_BIT_SET = 4'h5;
	localparam logic [3:0] OP_BIT_TEST_CLR = 4'h6;
	localparam logic [3:0] OP_BIT_TEST_SET = 4'h7;
	localparam logic [5:0] OP_ADD_WF = 6'h07;
	localparam logic [5:0] OP_AND_WF = 6'h05;
	localparam logic [1:0] PHASE_Q1 = 2'h0;
	localparam logic [1:0] PHASE_Q2 = 2'h1;
	localparam logic [1:0] PHASE_Q3 = 2'h2;
	localparam logic [1:0] PHASE_Q4 = 2'h3;
	typedef enum logic [2:0] {
		BOIE_OP_NONE,
		BOIE_OP_CLEAR,
		BOIE_OP_SET,
		BOIE_OP_TEST_CLR,
		BOIE_OP_TEST_SET,
		BOIE_OP_ADD,
		BOIE_OP_AND
	} boie_op_type;
endpackage : boie_pkg

// ### boie_decode.sv
// Combinational instruction decoder for the bit and register ops.
// Assumes the word is stable while the execute unit samples it.
`timescale 1ns/10ps
`default_nettype none
module boie_decode (
	input wire logic [boie_pkg::INSTR_W-1:0] instr_i,
	output boie_pkg::boie_op_type op_o,
	output logic [boie_pkg::ADDR_W-1:0] addr_o,
	output logic [boie_pkg::BIT_W-1:0] bit_idx_o,
	output logic dest_file_o
);
	logic [3:0] op4;
	logic [5:0] op6;
	// Field slices shared by all formats
	assign op4 = instr_i[boie_pkg::OP4_LSB +: 4];
	assign op6 = instr_i[boie_pkg::OP6_LSB +: 6];
	assign addr_o = instr_i[boie_pkg::ADDR_LSB +: boie_pkg::ADDR_W];
	assign bit_idx_o = instr_i[boie_pkg::BIT_LSB +: boie_pkg::BIT_W];
	assign dest_file_o = instr_i[boie_pkg::DEST_POS];
	// Opcode match; unknown words decode to no operation
	assign op_o = (op4 == boie_pkg::OP_BIT_CLEAR) ? boie_pkg::BOIE_OP_CLEAR :
		(op4 == boie_pkg::OP_BIT_SET) ? boie_pkg::BOIE_OP_SET :
		(op4 == boie_pkg::OP_BIT_TEST_CLR) ? boie_pkg::BOIE_OP_TEST_CLR :
		(op4 == boie_pkg::OP_BIT_TEST_SET) ? boie_pkg::BOIE_OP_TEST_SET :
		(op6 == boie_pkg::OP_ADD_WF) ? boie_pkg::BOIE_OP_ADD :
		(op6 == boie_pkg::OP_AND_WF) ? boie_pkg::BOIE_OP_AND :
		boie_pkg::BOIE_OP_NONE;
endmodule : boie_decode
`default_nettype wire

// ### boie_exec.sv
// Four-phase execute unit for bit clear, bit set, bit tests and the
// register add/AND write-back tail.
// Assumes instr_i holds the fetched word for a whole instruction cycle,
// file_rdata_i answers file_raddr_o combinationally, and the fetch stage
// advances one word per cycle; the skipped word is decoded here as an idle slot.
`timescale 1ns/10ps
`default_nettype none
module boie_exec #(
	parameter int DATA_W = boie_pkg::DATA_W
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [boie_pkg::INSTR_W-1:0] instr_i,
	input wire logic [DATA_W-1:0] file_rdata_i,
	input wire logic [DATA_W-1:0] work_i,
	output logic [boie_pkg::ADDR_W-1:0] file_raddr_o,
	output logic file_rd_o,
	output logic [boie_pkg::ADDR_W-1:0] file_waddr_o,
	output logic [DATA_W-1:0] file_wdata_o,
	output logic file_we_o,
	output logic [DATA_W-1:0] work_wdata_o,
	output logic work_we_o,
	output logic [DATA_W-1:0] alu_result_o,
	output logic flags_we_o,
	output logic [1:0] phase_o,
	output logic cycle_end_o,
	output logic skip_slot_o
);
	boie_pkg::boie_op_type dec_op;
	logic [boie_pkg::ADDR_W-1:0] dec_addr;
	logic [boie_pkg::BIT_W-1:0] dec_bit;
	logic dec_dest;

	boie_decode u_decode (
		.instr_i(instr_i),
		.op_o(dec_op),
		.addr_o(dec_addr),
		.bit_idx_o(dec_bit),
		.dest_file_o(dec_dest)
	);

	// Pipeline state held across the four phases
	logic [1:0] phase_r;
	boie_pkg::boie_op_type op_r;
	logic [boie_pkg::ADDR_W-1:0] addr_r;
	logic [boie_pkg::BIT_W-1:0] bit_r;
	logic dest_r;
	logic [DATA_W-1:0] operand_r;
	logic [DATA_W-1:0] result_r;
	logic skip_pend_r;
	logic skip_slot_r;
	logic rd_r;
	logic [boie_pkg::ADDR_W-1:0] raddr_r;
	logic we_r;
	logic [boie_pkg::ADDR_W-1:0] waddr_r;
	logic [DATA_W-1:0] wdata_r;
	logic wwe_r;
	logic [DATA_W-1:0] wwdata_r;
	logic flags_we_r;
	logic cycle_end_r;

	// One-hot mask of the selected bit
	function automatic logic [DATA_W-1:0] bit_mask(input logic [boie_pkg::BIT_W-1:0] idx);
		logic [DATA_W-1:0] m;
		m = '0;
		m[idx] = 1'b1;
		return m;
	endfunction : bit_mask

	// Phase decodes and process-step results
	logic in_q1;
	logic in_q2;
	logic in_q3;
	logic in_q4;
	logic is_bit_rmw;
	logic is_test;
	logic is_alu;
	logic tested_bit;
	logic skip_now;
	logic [DATA_W-1:0] mask;
	logic [DATA_W-1:0] process_val;
	logic [DATA_W-1:0] sum_val;
	logic [DATA_W-1:0] and_val;
	logic [1:0] phase_nxt;

	assign in_q1 = (phase_r == boie_pkg::PHASE_Q1);
	assign in_q2 = (phase_r == boie_pkg::PHASE_Q2);
	assign in_q3 = (phase_r == boie_pkg::PHASE_Q3);
	assign in_q4 = (phase_r == boie_pkg::PHASE_Q4);
	assign phase_nxt = phase_r + 2'h1;
	assign is_bit_rmw = (op_r == boie_pkg::BOIE_OP_CLEAR) || (op_r == boie_pkg::BOIE_OP_SET);
	assign is_test = (op_r == boie_pkg::BOIE_OP_TEST_CLR) || (op_r == boie_pkg::BOIE_OP_TEST_SET);
	assign is_alu = (op_r == boie_pkg::BOIE_OP_ADD) || (op_r == boie_pkg::BOIE_OP_AND);
	assign mask = bit_mask(bit_r);
	assign tested_bit = |(operand_r & mask);
	// Clear test skips on zero, set test on one; a one in the clear test runs on
	assign skip_now = ((op_r == boie_pkg::BOIE_OP_TEST_CLR) && !tested_bit) ||
		((op_r == boie_pkg::BOIE_OP_TEST_SET) && tested_bit);
	assign sum_val = operand_r + work_i;
	assign and_val = operand_r & work_i;
	// Clear and set move only the chosen bit, the rest of the byte passes through; add and AND give the whole byte
	assign process_val = (op_r == boie_pkg::BOIE_OP_CLEAR) ? (operand_r & ~mask) :
		(op_r == boie_pkg::BOIE_OP_SET) ? (operand_r | mask) :
		(op_r == boie_pkg::BOIE_OP_ADD) ? sum_val :
		(op_r == boie_pkg::BOIE_OP_AND) ? and_val :
		operand_r;

	// Phase counter, free running: one instruction cycle per four clocks
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			phase_r <= boie_pkg::PHASE_Q1;
		else
			phase_r <= phase_nxt;
	end

	// Q1 decode; a skipped slot decodes as idle so nothing is written
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			op_r <= boie_pkg::BOIE_OP_NONE;
			addr_r <= '0;
			bit_r <= '0;
			dest_r <= 1'b0;
		end
		else if (in_q1)
		begin
			op_r <= skip_pend_r ? boie_pkg::BOIE_OP_NONE : dec_op;
			addr_r <= dec_addr;
			bit_r <= dec_bit;
			dest_r <= dec_dest;
		end
	end

	// Q2 read of the addressed file register
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			rd_r <= 1'b0;
			raddr_r <= '0;
			operand_r <= '0;
		end
		else
		begin
			rd_r <= in_q1 && !skip_pend_r && (dec_op != boie_pkg::BOIE_OP_NONE);
			raddr_r <= in_q1 ? dec_addr : raddr_r;
			operand_r <= in_q2 ? file_rdata_i : operand_r;
		end
	end

	// Q3 process; skip decision is latched for the next cycle
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			result_r <= '0;
			skip_pend_r <= 1'b0;
		end
		else if (in_q3)
		begin
			result_r <= process_val;
			skip_pend_r <= is_test && skip_now;
		end
		else if (in_q4 && skip_slot_r)
			skip_pend_r <= 1'b0;
	end

	// Q4 write-back strobes, each one clock wide
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			we_r <= 1'b0;
			waddr_r <= '0;
			wdata_r <= '0;
			wwe_r <= 1'b0;
			wwdata_r <= '0;
			flags_we_r <= 1'b0;
		end
		else
		begin
			we_r <= in_q3 && (is_bit_rmw || (is_alu && dest_r));
			waddr_r <= addr_r;
			wdata_r <= process_val;
			wwe_r <= in_q3 && is_alu && !dest_r;
			wwdata_r <= process_val;
			flags_we_r <= in_q3 && is_alu;
		end
	end

	// Idle-slot marker spans the whole discarded cycle
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			skip_slot_r <= 1'b0;
			cycle_end_r <= 1'b0;
		end
		else
		begin
			skip_slot_r <= in_q4 ? skip_pend_r : skip_slot_r;
			cycle_end_r <= in_q3;
		end
	end

	assign file_raddr_o = raddr_r;
	assign file_rd_o = rd_r;
	assign file_waddr_o = waddr_r;
	assign file_wdata_o = wdata_r;
	assign file_we_o = we_r;
	assign work_wdata_o = wwdata_r;
	assign work_we_o = wwe_r;
	assign alu_result_o = result_r;
	assign flags_we_o = flags_we_r;
	assign phase_o = phase_r;
	assign cycle_end_o = cycle_end_r;
	assign skip_slot_o = skip_slot_r;
endmodule : boie_exec
`default_nettype wire

// ### boie_monitor.sv
// Port assertions for the bit-oriented execute block.
// Assumes instr_i and work_i are held for a whole instruction cycle.
`timescale 1ns/10ps
`default_nettype none
module boie_monitor #(
	parameter int DATA_W = 8
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [13:0] instr_i,
	input wire logic [DATA_W-1:0] file_rdata_i,
	input wire logic [DATA_W-1:0] work_i,
	input wire logic [6:0] file_raddr_o,
	input wire logic file_rd_o,
	input wire logic [DATA_W-1:0] file_wdata_o,
	input wire logic file_we_o,
	input wire logic [DATA_W-1:0] work_wdata_o,
	input wire logic work_we_o,
	input wire logic flags_we_o,
	input wire logic [1:0] phase_o,
	input wire logic skip_slot_o
);
	logic [DATA_W-1:0] mask;
	// Selected bit of the word in flight
	assign mask = DATA_W'(8'h01) << instr_i[9:7];
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);
	// Q1 decode of a live word, then its Q2 read
	sequence s_go(logic [3:0] op);
		phase_o == 2'h0 && instr_i[13:10] == op && !skip_slot_o;
	endsequence
	sequence s_rd;
		file_rd_o && phase_o == 2'h1 && file_raddr_o == instr_i[6:0];
	endsequence
	chk_clear_data: assert property (s_go(4'h4) |-> ##1 s_rd ##2
		file_we_o && file_wdata_o == ($past(file_rdata_i, 2) & ~mask)) else $error("bit clear wrong");
	chk_set_data: assert property (s_go(4'h5) |-> ##1 s_rd ##2
		file_we_o && file_wdata_o == ($past(file_rdata_i, 2) | mask)) else $error("bit set wrong");
	chk_bit_flags: assert property (phase_o == 2'h0 && instr_i[13:12] == 2'h1 |-> ##3 !flags_we_o)
		else $error("flags touched");
	chk_skip_taken: assert property (s_go(4'h6) ##1 (s_rd and (!file_rdata_i[instr_i[9:7]])) |->
		##2 !file_we_o ##1 skip_slot_o [*4]) else $error("skip missing");
	chk_skip_none: assert property (s_go(4'h6) ##1 (s_rd and (file_rdata_i[instr_i[9:7]])) |->
		##3 !skip_slot_o ##1 !skip_slot_o) else $error("false skip");
	// A discarded word must stay silent
	chk_skip_quiet: assert property (skip_slot_o |-> !file_rd_o && !file_we_o && !work_we_o)
		else $error("skip slot active");
	chk_add_dest: assert property (phase_o == 2'h0 && instr_i[13:7] == 7'h0E && !skip_slot_o |-> ##3
		work_we_o && !file_we_o && work_wdata_o == DATA_W'(work_i + $past(file_rdata_i, 2))) else $error("add dest");
	chk_and_dest: assert property (phase_o == 2'h0 && instr_i[13:7] == 7'h0B && !skip_slot_o |-> ##3
		file_we_o && !work_we_o && file_wdata_o == (work_i & $past(file_rdata_i, 2))) else $error("and dest");
endmodule : boie_monitor
bind boie_exec boie_monitor #(.DATA_W(DATA_W)) u_mon (.clk_i, .reset_n_i, .instr_i, .file_rdata_i, .work_i,
	.file_raddr_o, .file_rd_o, .file_wdata_o, .file_we_o, .work_wdata_o, .work_we_o, .flags_we_o, .phase_o,
	.skip_slot_o);
`default_nettype wire

// ### boie_file_model.sv
// File register array on the far side of the execute block.
// Assumes the bench preloads cells through the hierarchy.
`timescale 1ns/10ps
`default_nettype none
module boie_file_model (
	input wire logic clk_i,
	input wire logic rd_i,
	input wire logic [6:0] raddr_i,
	input wire logic we_i,
	input wire logic [6:0] waddr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o
);
	logic [7:0] mem [128];
	// Inverted byte off the strobe, so stale data never looks valid
	assign rdata_o = rd_i ? mem[raddr_i] : ~mem[raddr_i];
	// Write-back on the edge of the pulse
	always @(posedge clk_i)
		if (we_i)
			mem[waddr_i] <= wdata_i;
endmodule : boie_file_model
`default_nettype wire

// ### boie_exec_tb.sv
// Bench for the execute block: bit ops, skips and the add/AND tail.
// Assumes the file model answers reads at once; inputs move at negedge.
`timescale 1ns/10ps
`default_nettype none
module boie_exec_tb;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [13:0] instr_i = 14'h0000;
	logic [7:0] work_i = 8'h00;
	logic [7:0] file_rdata_i, file_wdata_o, work_wdata_o, alu_result_o, w_seen;
	logic [6:0] file_raddr_o, file_waddr_o;
	logic [1:0] phase_o;
	logic file_rd_o, file_we_o, work_we_o, flags_we_o, cycle_end_o, skip_slot_o, sk, ww, fl;
	logic [7:0] res;
	logic [2:0] ce;
	int miscompares = 0;
	int comparisons = 0;
	int cycles = 0;
	boie_exec u_dut (.clk_i, .reset_n_i, .instr_i, .file_rdata_i, .work_i, .file_raddr_o, .file_rd_o,
		.file_waddr_o, .file_wdata_o, .file_we_o, .work_wdata_o, .work_we_o, .alu_result_o, .flags_we_o,
		.phase_o, .cycle_end_o, .skip_slot_o);
	boie_file_model u_file (.clk_i, .rd_i(file_rd_o), .raddr_i(file_raddr_o), .we_i(file_we_o),
		.waddr_i(file_waddr_o), .wdata_i(file_wdata_o), .rdata_o(file_rdata_i));
	// Free-running 8 ns clock
	initial
		forever
			#4 clk_i = ~clk_i;
	task automatic summarize;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : summarize
	// Ceiling far above the hundred or so cycles the tests need
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			miscompares++;
			summarize();
		end
	end
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	// Issue one word for its Q1 edge and watch its four phases
	task automatic run(input logic [13:0] ins);
		while (phase_o !== 2'h0)
			@(negedge clk_i);
		instr_i = ins;
		{sk, ww, fl} = 3'h0;
		ce = 3'h0;
		repeat (4)
		begin
			@(negedge clk_i);
			sk |= skip_slot_o;
			fl |= flags_we_o;
			ce += {2'h0, cycle_end_o};
			if (work_we_o === 1'b1)
			begin
				ww = 1'b1;
				w_seen = work_wdata_o;
			end
		end
		// Processed byte stands from Q4 until the next Q4
		res = alu_result_o;
	endtask : run
	// Every bit index, clear then set back to back, plus the top address
	task automatic t_bits;
		for (int b = 0; b < 8; b++)
		begin
			u_file.mem[b] = 8'hA5;
			run({4'h4, 3'(b), 7'(b)});
			cmp(u_file.mem[b], 8'hA5 & ~(8'h01 << b));
			cmp({7'h00, fl}, 8'h00);
			cmp(res, 8'hA5 & ~(8'h01 << b));
			cmp({5'h00, ce}, 8'h01);
			run({4'h5, 3'(b), 7'(b)});
			cmp(u_file.mem[b], 8'hA5 | (8'h01 << b));
		end
		u_file.mem[127] = 8'h0A;
		run({4'h5, 3'h7, 7'h7F});
		cmp(u_file.mem[127], 8'h8A);
	endtask : t_bits
	// Skip taken, then not taken; the word after each tells which
	task automatic t_skip;
		u_file.mem[32] = 8'hFD;
		u_file.mem[33] = 8'h00;
		run({4'h6, 3'h1, 7'h20});
		run({4'h5, 3'h0, 7'h21});
		cmp({7'h00, sk}, 8'h01);
		cmp(u_file.mem[33], 8'h00);
		run({4'h5, 3'h1, 7'h21});
		cmp(u_file.mem[33], 8'h02);
		cmp(u_file.mem[32], 8'hFD);
		u_file.mem[32] = 8'h02;
		run({4'h6, 3'h1, 7'h20});
		run({4'h5, 3'h0, 7'h21});
		cmp({7'h00, sk}, 8'h00);
		cmp(u_file.mem[33], 8'h03);
		// Set test on a one skips the word after it
		run({4'h7, 3'h1, 7'h20});
		run({4'h5, 3'h2, 7'h21});
		cmp({7'h00, sk}, 8'h01);
		cmp(u_file.mem[33], 8'h03);
	endtask : t_skip
	// Destination bit steers the add and AND results
	task automatic t_alu;
		u_file.mem[4] = 8'hC2;
		work_i = 8'h17;
		run({6'h07, 1'b0, 7'h04});
		cmp(w_seen, 8'hD9);
		cmp(res, 8'hD9);
		cmp({6'h00, ww, fl}, 8'h03);
		cmp(u_file.mem[4], 8'hC2);
		run({6'h05, 1'b1, 7'h04});
		cmp(u_file.mem[4], 8'h02);
		cmp({7'h00, ww}, 8'h00);
	endtask : t_alu
	initial
	begin
		repeat (2) @(negedge clk_i);
		// Strobes quiet and phase at Q1 while reset is held
		cmp({file_rd_o, file_we_o, work_we_o, flags_we_o, cycle_end_o, skip_slot_o, phase_o}, 8'h00);
		reset_n_i = 1'b1;
		t_bits();
		t_skip();
		t_alu();
		summarize();
	end
endmodule : boie_exec_tb
`default_nettype wire
